// ---- core/fspc_ctrl.sv ----
// Summary of operation
// - Ready interrupt requested while its enable, global enable set and enable bit clear.
// - Erase or write into read-while-write section sets busy and blocks that section.
// - Busy clears on re-enable after the operation, or when a buffer load starts.
// - Bit 5 reads zero and ignores writes.
// - Re-enable plus enable arms; store within four cycles unblocks; refused while a timed operation runs.
// - Re-enable written during buffer fill aborts the fill and discards the data.
// - Lock-set plus enable; store within four cycles programs lock bits from R0.
// - Lock-set clears when the lock write ends or the window lapses.
// - Load within three cycles of lock-set returns lock or fuse byte by Z bit 0.
// - Page-write plus enable; store within four cycles writes buffer to Z page.
// - Page-write clears when the write ends or the window lapses.
// - Page-erase plus enable; store within four cycles erases Z page.
// - Page-erase clears when the erase ends or the window lapses.
// - Erase or write in no-read-while-write section stalls the CPU throughout.
// - Enable permits a store only in the following four cycles.
// - Enable alone: store loads R1:R0 into buffer word Z[6:1].
// - Enable clears after the store or window lapse; stays set during erase/write.
// - Only five command patterns arm; any other pattern does nothing.
// - Six lock bits, one when unprogrammed, upper two bits read one.
// - Lock bits return to one only by chip erase or reset.
// - General lock modes 2 and 3 restrict external programming, verification and locks.
// - Application lock modes gate stores, boot-side loads and interrupts.
// - Page from Z[14:7], word from Z[6:1].
// - Erase, write and lock write take between 3.7 ms and 4.5 ms.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

module fspc_ctrl
    import fspc_pkg::*;
#(
    parameter int PROG_CYCLES = fspc_pkg::FSPC_PROG_CYCLES
)
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst_b,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [7:0]                     reg_rdata,
    input  wire fspc_pkg::fspc_cpu_req_t   cpu_req,
    input  wire logic [7:0]                fuse_bits,
    input  wire logic [1:0]                boot_size,
    input  wire logic                      chip_erase,
    output logic [7:0]                     lpm_data,
    output logic                           lpm_valid,
    output fspc_pkg::fspc_flash_cmd_t      flash_cmd,
    output logic                           rww_access_block,
    output logic                           cpu_stall,
    output logic                           spm_ready_irq,
    output logic [7:0]                     lock_byte,
    output fspc_pkg::fspc_protect_t        protect
);
    import fspc_pkg::*;

    typedef struct packed {
        logic            irq_en;
        logic            busy;
        logic [4:0]      cmd;
        logic            armed;
        logic [2:0]      arm_cnt;
        fspc_op_t        op;
        logic [17:0]     op_cnt;
        logic            op_no_read_while_write_section;
        logic            op_lock;
        logic [5:0]      lock_pend;
        logic            filling;
        logic [5:0]      lock;
        logic [7:0]      rdata;
        logic [7:0]      lpm_data;
        logic            lpm_valid;
        fspc_flash_cmd_t fcmd;
        logic            stall;
        logic            irq;
        fspc_protect_t   prot;
    } fspc_state_t;

    localparam logic [17:0] OP_LAST = 18'(PROG_CYCLES - 1);

    fspc_state_t st_reg;
    fspc_state_t st_next;

    function automatic logic cmd_legal(input logic [4:0] c);
        cmd_legal = (c == FSPC_CMD_REEN) || (c == FSPC_CMD_LOCKSET) ||
                    (c == FSPC_CMD_PAGE_WRITE_CMD) || (c == FSPC_CMD_PAGE_ERASE_CMD) ||
                    (c == FSPC_CMD_LOAD);
    endfunction

    // Lock pair in modes 3 or 4 (high bit programmed) forbids cross-section reads.
    function automatic logic lpm_locked(input logic hi);
        lpm_locked = (hi == 1'b0);
    endfunction

    logic [7:0] boot_first_page;
    logic [7:0] z_page;
    logic       page_in_boot;
    logic       spm_ok;
    logic       lpm_ok;
    logic       spm_blocked;

    always_comb
    begin
        boot_first_page = 8'h00 - (FSPC_BOOT_MIN_PAGES << (~boot_size));
        z_page          = cpu_req.z[14:7];
        page_in_boot    = (z_page >= boot_first_page);
        spm_ok          = st_reg.armed && cpu_req.spm && (st_reg.arm_cnt < FSPC_ARM_CYCLES);
        lpm_ok          = st_reg.armed && cpu_req.lpm && (st_reg.cmd == FSPC_CMD_LOCKSET) &&
                          (st_reg.arm_cnt < FSPC_LPM_CYCLES);
        spm_blocked     = page_in_boot ? (st_reg.lock[4] == 1'b0)
                                       : (st_reg.lock[2] == 1'b0);
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.rdata     = 8'h00;
        st_next.lpm_valid = 1'b0;
        st_next.fcmd.buf_load   = 1'b0;
        st_next.fcmd.buf_clear  = 1'b0;
        st_next.fcmd.page_erase = 1'b0;
        st_next.fcmd.page_write = 1'b0;

        if (st_reg.armed)
        begin
            st_next.arm_cnt = st_reg.arm_cnt + 3'h1;
            if (st_reg.arm_cnt == FSPC_ARM_CYCLES - 3'h1)
            begin
                st_next.armed = 1'b0;
                st_next.cmd   = 5'h00;
            end
        end

        if (lpm_ok)
        begin
            st_next.lpm_valid = 1'b1;
            st_next.lpm_data  = cpu_req.z[0] ? fuse_bits
                                             : {FSPC_LOCK_UNUSED, st_reg.lock};
        end

        if (spm_ok)
        begin
            st_next.armed = 1'b0;
            st_next.cmd   = 5'h00;
            case (st_reg.cmd)
                FSPC_CMD_REEN:
                begin
                    st_next.busy = 1'b0;
                end
                FSPC_CMD_LOCKSET:
                begin
                    st_next.cmd       = st_reg.cmd;
                    st_next.op        = FSPC_BUSY;
                    st_next.op_cnt    = 18'h00000;
                    st_next.op_lock   = 1'b1;
                    st_next.op_no_read_while_write_section   = 1'b0;
                    st_next.lock_pend = st_reg.lock & cpu_req.r0[5:0];
                end
                FSPC_CMD_PAGE_WRITE_CMD,
                FSPC_CMD_PAGE_ERASE_CMD:
                begin
                    if (!spm_blocked)
                    begin
                        st_next.cmd     = st_reg.cmd;
                        st_next.op      = FSPC_BUSY;
                        st_next.op_cnt  = 18'h00000;
                        st_next.op_lock = 1'b0;
                        st_next.op_no_read_while_write_section = (z_page >= FSPC_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
                        st_next.stall   = (z_page >= FSPC_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
                        if (z_page < FSPC_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
                        begin
                            st_next.busy = 1'b1;
                        end
                        st_next.fcmd.page_sel = z_page;
                        if (st_reg.cmd == FSPC_CMD_PAGE_WRITE_CMD)
                        begin
                            st_next.fcmd.page_write = 1'b1;
                            st_next.filling         = 1'b0;
                        end
                        else
                        begin
                            st_next.fcmd.page_erase = 1'b1;
                        end
                    end
                end
                FSPC_CMD_LOAD:
                begin
                    st_next.busy          = 1'b0;
                    st_next.filling       = 1'b1;
                    st_next.fcmd.buf_load = 1'b1;
                    st_next.fcmd.word_sel = cpu_req.z[6:1];
                    st_next.fcmd.data     = {cpu_req.r1, cpu_req.r0};
                end
                default:
                begin
                    st_next.cmd = 5'h00;
                end
            endcase
        end

        case (st_reg.op)
            FSPC_IDLE:
            begin
                st_next.stall = st_next.stall;
            end
            FSPC_BUSY:
            begin
                st_next.op_cnt = st_reg.op_cnt + 18'h00001;
                if (st_reg.op_cnt == OP_LAST)
                begin
                    st_next.op    = FSPC_IDLE;
                    st_next.cmd   = 5'h00;
                    st_next.stall = 1'b0;
                    if (st_reg.op_lock)
                    begin
                        st_next.lock = st_reg.lock_pend;
                    end
                end
            end
            default:
            begin
                st_next.op = FSPC_IDLE;
            end
        endcase

        if (reg_wr && (reg_addr == FSPC_CSR_OFFSET))
        begin
            st_next.irq_en = reg_wdata[FSPC_BIT_IRQ_EN];
            // Command writes are ignored while a timed operation owns the bits.
            if ((st_reg.op == FSPC_IDLE) && cmd_legal(reg_wdata[4:0]))
            begin
                st_next.cmd     = reg_wdata[4:0];
                st_next.armed   = 1'b1;
                st_next.arm_cnt = 3'h0;
                if ((reg_wdata[4:0] == FSPC_CMD_REEN) && st_reg.filling)
                begin
                    // A buffer load landing in the same cycle keeps the fill open.
                    st_next.filling        = st_next.fcmd.buf_load;
                    st_next.fcmd.buf_clear = 1'b1;
                end
            end
        end

        if (reg_rd)
        begin
            if (reg_addr == FSPC_CSR_OFFSET)
            begin
                st_next.rdata = {st_reg.irq_en, st_reg.busy, 1'b0, st_reg.cmd};
            end
        end

        if (chip_erase)
        begin
            st_next.lock = FSPC_LOCK_RESET;
        end

        st_next.irq = st_reg.irq_en && cpu_req.global_irq && !st_reg.cmd[0];

        st_next.prot.ext_prog_block   = !st_reg.lock[0];
        st_next.prot.fuse_locked      = !st_reg.lock[0];
        st_next.prot.ext_verify_block = !st_reg.lock[0] && !st_reg.lock[1];
        st_next.prot.boot_lock_locked = !st_reg.lock[0] && !st_reg.lock[1];
        st_next.prot.app_spm_block    = !st_reg.lock[2];
        st_next.prot.app_lpm_block    = lpm_locked(st_reg.lock[3]);
        st_next.prot.boot_spm_block   = !st_reg.lock[4];
        st_next.prot.boot_lpm_block   = lpm_locked(st_reg.lock[5]);
        st_next.prot.irq_block        =
            (!cpu_req.exec_in_boot && cpu_req.vectors_in_boot &&
             lpm_locked(st_reg.lock[3])) ||
            (cpu_req.exec_in_boot && !cpu_req.vectors_in_boot &&
             lpm_locked(st_reg.lock[5]));
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg           <= '0;
            st_reg.irq_en    <= FSPC_CSR_RESET[FSPC_BIT_IRQ_EN];
            st_reg.op        <= FSPC_IDLE;
            st_reg.lock      <= FSPC_LOCK_RESET;
            st_reg.lock_pend <= FSPC_LOCK_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata        = st_reg.rdata;
    assign lpm_data         = st_reg.lpm_data;
    assign lpm_valid        = st_reg.lpm_valid;
    assign flash_cmd        = st_reg.fcmd;
    assign rww_access_block = st_reg.busy;
    assign cpu_stall        = st_reg.stall;
    assign spm_ready_irq    = st_reg.irq;
    assign lock_byte        = {FSPC_LOCK_UNUSED, st_reg.lock};
    assign protect          = st_reg.prot;

endmodule // fspc_ctrl

// ---- core/fspc_pkg.sv ----
package fspc_pkg;

    localparam logic [7:0] FSPC_CSR_OFFSET = 8'h37;

    // Control/status bit positions.
    localparam int FSPC_BIT_IRQ_EN  = 7;
    localparam int FSPC_BIT_BUSY    = 6;
    localparam int FSPC_BIT_RESV    = 5;
    localparam int FSPC_BIT_REEN    = 4;
    localparam int FSPC_BIT_LOCKSET = 3;
    localparam int FSPC_BIT_PAGE_WRITE_CMD   = 2;
    localparam int FSPC_BIT_PAGE_ERASE_CMD   = 1;
    localparam int FSPC_BIT_STORE_PROG_ENABLE   = 0;

    localparam logic [7:0] FSPC_CSR_RESET = 8'h00;

    // Legal patterns of the five command bits.
    localparam logic [4:0] FSPC_CMD_REEN    = 5'h11;
    localparam logic [4:0] FSPC_CMD_LOCKSET = 5'h09;
    localparam logic [4:0] FSPC_CMD_PAGE_WRITE_CMD   = 5'h05;
    localparam logic [4:0] FSPC_CMD_PAGE_ERASE_CMD   = 5'h03;
    localparam logic [4:0] FSPC_CMD_LOAD    = 5'h01;

    localparam logic [2:0] FSPC_ARM_CYCLES = 3'h4;
    localparam logic [2:0] FSPC_LPM_CYCLES = 3'h3;

    localparam logic [5:0] FSPC_LOCK_RESET = 6'h3F;
    localparam logic [1:0] FSPC_LOCK_UNUSED = 2'h3;

    // First page of the no-read-while-write section.
    localparam logic [7:0] FSPC_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'hE0;
    localparam logic [7:0] FSPC_BOOT_MIN_PAGES  = 8'h04;

    localparam int FSPC_CLK_PERIOD_NS  = 25;
    localparam int FSPC_PROG_MIN_NS    = 3700000;
    localparam int FSPC_PROG_MAX_NS    = 4500000;
    localparam int FSPC_PROG_CYCLES    =
        (FSPC_PROG_MIN_NS + FSPC_CLK_PERIOD_NS - 1) / FSPC_CLK_PERIOD_NS;
    localparam int FSPC_PROG_MAX_CYCLES = FSPC_PROG_MAX_NS / FSPC_CLK_PERIOD_NS;

    typedef enum logic [0:0] {FSPC_IDLE, FSPC_BUSY} fspc_op_t;

    typedef struct packed {
        logic        spm;
        logic        lpm;
        logic [15:0] z;
        logic [7:0]  r0;
        logic [7:0]  r1;
        logic        global_irq;
        logic        exec_in_boot;
        logic        vectors_in_boot;
    } fspc_cpu_req_t;

    typedef struct packed {
        logic        buf_load;
        logic        buf_clear;
        logic        page_erase;
        logic        page_write;
        logic [7:0]  page_sel;
        logic [5:0]  word_sel;
        logic [15:0] data;
    } fspc_flash_cmd_t;

    typedef struct packed {
        logic ext_prog_block;
        logic ext_verify_block;
        logic fuse_locked;
        logic boot_lock_locked;
        logic app_spm_block;
        logic app_lpm_block;
        logic boot_spm_block;
        logic boot_lpm_block;
        logic irq_block;
    } fspc_protect_t;

endpackage

// ---- tb/fspc_properties.sv ----
`timescale 1ns/1ps
module fspc_properties
#(
    parameter int PROG_CYCLES = 16
)
(
    input wire logic                      clk_sys,
    input wire logic                      rst_b,
    input wire logic [7:0]                reg_rdata,
    input wire fspc_pkg::fspc_cpu_req_t   cpu_req,
    input wire logic                      chip_erase,
    input wire logic                      lpm_valid,
    input wire fspc_pkg::fspc_flash_cmd_t flash_cmd,
    input wire logic                      rww_access_block,
    input wire logic                      cpu_stall,
    input wire logic                      spm_ready_irq,
    input wire logic [7:0]                lock_byte,
    input wire fspc_pkg::fspc_protect_t   protect
);
    import fspc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    int   stall_cnt;
    logic prog_go;
    assign prog_go = flash_cmd.page_erase || flash_cmd.page_write;
    always_ff @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            stall_cnt <= 0;
        else
            stall_cnt <= cpu_stall ? stall_cnt + 1 : 0;
    a_reserved_zero: assert property (reg_rdata[5] == 1'b0)
        else $error("reserved bit set");
    a_busy_rww: assert property (prog_go && flash_cmd.page_sel < FSPC_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE
        |-> rww_access_block && !cpu_stall) else $error("busy not set");
    a_stall_no_read_while_write_section: assert property (prog_go && flash_cmd.page_sel >= FSPC_NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE
        |-> cpu_stall && $stable(rww_access_block)) else $error("stall not set");
    a_busy_cause: assert property ($changed(rww_access_block) |-> $past(cpu_req.spm))
        else $error("busy moved without store");
    a_irq_global: assert property (spm_ready_irq |-> $past(cpu_req.global_irq))
        else $error("irq without global enable");
    a_lpm_cause: assert property (lpm_valid |-> $past(cpu_req.lpm))
        else $error("lpm data without load");
    a_lock_upper: assert property (lock_byte[7:6] == 2'b11)
        else $error("unused lock bits low");
    a_lock_sticky: assert property (!$past(chip_erase) && !$past(chip_erase, 2)
        |-> (lock_byte[5:0] & ~$past(lock_byte[5:0])) == 6'h00) else $error("lock unprogrammed");
    a_general_lock: assert property ($stable(lock_byte) |-> protect.ext_prog_block == !lock_byte[0]
        && protect.ext_verify_block == (lock_byte[1:0] == 2'b00)) else $error("general lock");
    a_section_lock: assert property ($stable(lock_byte) |-> protect.app_spm_block == !lock_byte[2]
        && protect.boot_spm_block == !lock_byte[4]) else $error("section lock");
    a_prog_bound: assert property (stall_cnt <= PROG_CYCLES + 2)
        else $error("stall too long");
endmodule // fspc_properties

bind fspc_ctrl fspc_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (.clk_sys, .rst_b,
    .reg_rdata, .cpu_req, .chip_erase, .lpm_valid, .flash_cmd, .rww_access_block, .cpu_stall,
    .spm_ready_irq, .lock_byte, .protect);

// ---- tb/fspc_cpu_model.sv ----
`timescale 1ns/1ps
module fspc_cpu_model
(
    input  wire logic              clk_sys,
    output fspc_pkg::fspc_cpu_req_t cpu_req
);
    import fspc_pkg::*;
    initial cpu_req = '0;
    // Issues one store or load after dly edges; operands are scrambled once it is taken.
    task automatic issue(input logic ld, input int dly, input logic [15:0] z, input logic [15:0] d);
        repeat (dly) @(posedge clk_sys);
        cpu_req.spm <= !ld;
        cpu_req.lpm <= ld;
        cpu_req.z <= z;
        {cpu_req.r1, cpu_req.r0} <= d;
        @(posedge clk_sys);
        cpu_req.spm <= 1'b0;
        cpu_req.lpm <= 1'b0;
        cpu_req.z <= ~z;
        {cpu_req.r1, cpu_req.r0} <= ~d;
    endtask
    task automatic levels(input logic gi, input logic eb, input logic vb);
        cpu_req.global_irq <= gi;
        cpu_req.exec_in_boot <= eb;
        cpu_req.vectors_in_boot <= vb;
    endtask
endmodule // fspc_cpu_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench;
    import fspc_pkg::*;
    localparam int PROG = 16;
    logic            clk_sys = 1'b0;
    logic            rst_b = 1'b0;
    logic [7:0]      reg_addr = FSPC_CSR_OFFSET;
    logic [7:0]      reg_wdata = 8'h00;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [7:0]      fuse_bits = 8'h5A;
    logic [1:0]      boot_size = 2'h3;
    logic            chip_erase = 1'b0;
    logic [7:0]      reg_rdata;
    logic [7:0]      lpm_data;
    logic            lpm_valid;
    logic            rww_access_block;
    logic            cpu_stall;
    logic            spm_ready_irq;
    logic [7:0]      lock_byte;
    fspc_cpu_req_t   cpu_req;
    fspc_flash_cmd_t flash_cmd;
    fspc_protect_t   protect;
    logic [4:0]      seen = 5'h00;
    logic [7:0]      lpm_cap = 8'h00;
    logic [7:0]      v;
    int              failures = 0;
    int              n_tests = 0;
    int              cycles = 0;
    logic [23:0]     rows [9] = '{24'h818180, 24'h090900, 24'h050500, 24'h030300, 24'h111100,
                                  24'h210100, 24'h070000, 24'h5F0000, 24'hE08080};
    fspc_ctrl #(.PROG_CYCLES(PROG)) u_fspc_ctrl (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .cpu_req, .fuse_bits, .boot_size, .chip_erase, .lpm_data,
        .lpm_valid, .flash_cmd, .rww_access_block, .cpu_stall, .spm_ready_irq, .lock_byte,
        .protect);
    fspc_cpu_model u_fspc_cpu_model (.clk_sys, .cpu_req);
    always #12.5 clk_sys = ~clk_sys;
    // Pulses are latched so that tests can look for them after the fact.
    always @(posedge clk_sys)
    begin
        seen <= seen | {flash_cmd.buf_load, flash_cmd.buf_clear, flash_cmd.page_erase,
                        flash_cmd.page_write, lpm_valid};
        if (lpm_valid)
            lpm_cap <= lpm_data;
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(output logic [7:0] d);
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys) d = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic op(input logic [7:0] c, input logic ld, input int dly, input logic [15:0] z,
                      input logic [15:0] d);
        @(negedge clk_sys) seen = 5'h00;
        @(posedge clk_sys);
        wr(c);
        u_fspc_cpu_model.issue(ld, dly, z, d);
        repeat (3) @(posedge clk_sys);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        `CHK("lock reset", 8'hFF, lock_byte)
        reg_addr <= 8'h38;
        wr(8'h81);
        rd(v);
        `CHK("unmapped", 8'h00, v)
        reg_addr <= FSPC_CSR_OFFSET;
        rd(v);
        `CHK("csr reset", 8'h00, v)
        $display("reset test done");
        u_fspc_cpu_model.levels(1'b1, 1'b0, 1'b0);
        foreach (rows[i])
        begin
            wr(rows[i][23:16]);
            rd(v);
            `CHK("csr armed", rows[i][15:8], v)
            repeat (5) @(posedge clk_sys);
            rd(v);
            `CHK("csr lapsed", rows[i][7:0], v)
        end
        `CHK("irq on", 1'b1, spm_ready_irq)
        wr(8'h81);
        rd(v);
        `CHK("irq armed", 1'b0, spm_ready_irq)
        $display("table test done");
        op(8'h01, 1'b0, 3, 16'h0047, 16'hBEEF);
        `CHK("load last", 5'b10000, seen)
        `CHK("word", 6'h23, flash_cmd.word_sel)
        `CHK("data", 16'hBEEF, flash_cmd.data)
        rd(v);
        `CHK("csr load", 8'h00, v)
        op(8'h01, 1'b0, 4, 16'h0002, 16'h1234);
        `CHK("load late", 5'b00000, seen)
        wr(8'h01);
        op(8'h01, 1'b0, 3, 16'h0002, 16'h1234);
        `CHK("rearm", 5'b10000, seen)
        $display("window test done");
        op(8'h03, 1'b0, 0, 16'h0800, 16'h0000);
        `CHK("erase", 5'b00100, seen)
        `CHK("page", 8'h10, flash_cmd.page_sel)
        `CHK("busy", 1'b1, rww_access_block)
        op(8'h11, 1'b0, 0, 16'h0000, 16'h0000);
        rd(v);
        `CHK("csr erasing", 8'h43, v)
        repeat (PROG + 4) @(posedge clk_sys);
        rd(v);
        `CHK("csr erased", 8'h40, v)
        op(8'h11, 1'b0, 0, 16'h0000, 16'h0000);
        `CHK("reenable", 1'b0, rww_access_block)
        op(8'h05, 1'b0, 0, 16'h0900, 16'h0000);
        `CHK("write", 5'b00010, seen)
        repeat (PROG + 4) @(posedge clk_sys);
        rd(v);
        `CHK("csr written", 8'h40, v)
        op(8'h01, 1'b0, 0, 16'h0002, 16'h5555);
        `CHK("load clears busy", 1'b0, rww_access_block)
        op(8'h11, 1'b0, 0, 16'h0000, 16'h0000);
        `CHK("fill abort", 1'b1, seen[3])
        op(8'h03, 1'b0, 0, 16'h7400, 16'h0000);
        `CHK("stall", 2'b10, {cpu_stall, rww_access_block})
        repeat (PROG + 4) @(posedge clk_sys);
        `CHK("stall end", 1'b0, cpu_stall)
        $display("program test done");
        op(8'h09, 1'b0, 0, 16'h0000, 16'hFF32);
        repeat (PROG + 4) @(posedge clk_sys);
        `CHK("lock set", 8'hF2, lock_byte)
        rd(v);
        `CHK("csr locked", 8'h00, v)
        `CHK("mode 2", 2'b10, {protect.ext_prog_block, protect.ext_verify_block})
        op(8'h09, 1'b0, 0, 16'h0000, 16'h003C);
        repeat (PROG + 4) @(posedge clk_sys);
        `CHK("lock sticky", 8'hF0, lock_byte)
        `CHK("mode 3", 1'b1, protect.ext_verify_block)
        op(8'h03, 1'b0, 0, 16'h0800, 16'h0000);
        `CHK("app locked", 5'b00000, seen)
        u_fspc_cpu_model.levels(1'b1, 1'b0, 1'b1);
        repeat (2) @(posedge clk_sys);
        `CHK("irq gate", 1'b1, protect.irq_block)
        `CHK("protect", 9'h1F9, protect)
        $display("lock test done");
        op(8'h09, 1'b1, 0, 16'h0000, 16'h0000);
        `CHK("lock read", 8'hF0, lpm_cap)
        op(8'h09, 1'b1, 2, 16'h0001, 16'h0000);
        `CHK("fuse read", 8'h5A, lpm_cap)
        op(8'h01, 1'b1, 0, 16'h0000, 16'h0000);
        `CHK("read unarmed", 1'b0, seen[0])
        chip_erase <= 1'b1;
        @(posedge clk_sys);
        chip_erase <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("chip erase", 8'hFF, lock_byte)
        wr(8'h83);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(v);
        `CHK("csr mid reset", 8'h00, v)
        `CHK("lock mid reset", 8'hFF, lock_byte)
        $display("read test done");
        print_verdict();
    end
endmodule // testbench
